// file: include/objdir_pkg.sv
// object directory constants: indices, subindices, field layouts, reset values
// assumes nothing; shared by the directory and its testbench
package objdir_pkg;

  // ****************************************
  // addressing
  // ****************************************
  localparam int IDX_W = 16;
  localparam int SUB_W = 8;
  localparam logic [15:0] IDX_DEVICE_KIND = 16'h1000;
  localparam logic [15:0] IDX_ERROR_SUMMARY = 16'h1001;
  localparam logic [15:0] IDX_MAKER_STATUS = 16'h1002;
  localparam logic [15:0] IDX_ERROR_HISTORY = 16'h1003;
  localparam logic [15:0] IDX_SYNC_ID = 16'h1005;
  localparam logic [15:0] COMM_SEG_LO = 16'h1000;
  localparam logic [15:0] COMM_SEG_HI = 16'h1fff;
  localparam logic [15:0] MAKER_SEG_LO = 16'h2000;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_NEWEST = 8'h01;
  localparam logic [7:0] SUB_OLDEST = 8'h20;

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [31:0] DEVICE_KIND_VAL = 32'h0000_0000;
  localparam int HIST_DEPTH = 32;
  localparam int ESUM_GENERIC = 0;
  localparam int ESUM_COMM = 4;
  localparam logic [7:0] ESUM_LIVE_MASK = 8'h11;
  localparam logic [10:0] SYNC_ID_RESET = 11'h080;
  localparam int SYNC_ID_W = 11;
  localparam int SYNC_BIT_FREE = 31;
  localparam int SYNC_BIT_PRODUCE = 30;
  localparam int SYNC_BIT_EXT = 29;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;
  localparam int NODE_W = 7;
  localparam int FUNC_W = 4;

  // ****************************************
  // abort codes returned on refused accesses
  // ****************************************
  localparam logic [31:0] ABORT_NO_OBJECT = 32'h0602_0000;
  localparam logic [31:0] ABORT_NO_SUB = 32'h0609_0011;
  localparam logic [31:0] ABORT_READ_ONLY = 32'h0601_0002;
  localparam logic [31:0] ABORT_BAD_VALUE = 32'h0609_0030;
  localparam logic [31:0] ABORT_NOT_MAPPABLE = 32'h0604_0041;

endpackage

// file: hw/error_history.sv
// error history store: newest entry at position 0, older ones shift down
// assumes pushes and clears come from logic on the same clock
`timescale 1ns/100ps
module error_history #(
  parameter int DEPTH = 32,
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // update side
  input wire logic push,
  input wire logic [W-1:0] push_data,
  input wire logic clear,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_sel,
  output logic [W-1:0] rd_data,
  output logic [$clog2(DEPTH):0] count
);

  localparam int CW = $clog2(DEPTH) + 1;

  logic [W-1:0] entry_q [DEPTH];
  logic [CW-1:0] count_q;

  // ****************************************
  // entries shift on every push; oldest falls off the end
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry_q[i] <= '0;
      end
    end else if (push) begin
      entry_q[0] <= push_data;
      for (int i = 1; i < DEPTH; i++) begin
        entry_q[i] <= entry_q[i-1];
      end
    end
  end

  // count saturates at depth; a push in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (push) begin
      if (clear) begin
        count_q <= CW'(1);
      end else if (count_q != CW'(DEPTH)) begin
        count_q <= count_q + CW'(1);
      end
    end else if (clear) begin
      count_q <= '0;
    end
  end

  // entries beyond the count read as no error
  assign rd_data = (CW'(rd_sel) < count_q) ? entry_q[rd_sel] : '0;
  assign count = count_q;

endmodule

// file: hw/sensor_object_directory.sv
// communication segment of the sensor's parameter_directory, with frame checks
// assumes the frame controller and the transfer engines run on clk;
// the node number strap comes from pins and is synchronised here
//
// Notes on behaviour
// - Only 11-bit identifiers are handled; frames with 29-bit identifiers are refused.
// - Every entry is selected by a 16-bit index with an 8-bit subindex.
// - Predefined communication objects live in indices 0x1000 to 0x1fff.
// - Maker objects live at indices from 0x2000 upward.
// - Mapping into process data is refused unless the object is marked mappable.
// - The device kind word at 0x1000 sub 0 is a read-only 32-bit zero.
// - The error summary at 0x1001 is a read-only byte that is zero after reset.
// - Bit 0 of the error summary is set on every raised error.
// - Bit 4 of the error summary flags a communication error and bit 7 reads zero.
// - Error history holds 32 entries, sub 0 the writable count, 0x01 newest, 0x20 oldest.
// - The sync identifier at 0x1005 is a 32-bit read/write word, id in bits 10:0, reset 0x80.
// - In the sync identifier bits 30 and 29 stay zero and bit 31 is free.
// - A message is one identifier and at most 8 data bytes.
// - The outgoing identifier joins a function code and the node number.
`timescale 1ns/100ps
module sensor_object_directory #(
  parameter logic [15:0] MAP_INDEX = 16'h2000,
  parameter logic [7:0] MAP_SUB = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // directory access from the transfer engine
  input wire logic acc_req,
  input wire logic acc_write,
  input wire logic [15:0] acc_index,
  input wire logic [7:0] acc_sub,
  input wire logic [31:0] acc_wdata,
  output logic acc_done,
  output logic [31:0] acc_rdata,
  output logic acc_abort,
  output logic [31:0] acc_abort_code,
  output logic acc_maker_seg,
  // mapping query from the process data engine
  input wire logic map_req,
  input wire logic [15:0] map_index,
  input wire logic [7:0] map_sub,
  output logic map_done,
  output logic map_ok,
  // error events from the device
  input wire logic err_raise,
  input wire logic err_comm,
  input wire logic [31:0] err_code,
  input wire logic err_all_clear,
  input wire logic [31:0] maker_status,
  // received frame from the frame controller
  input wire logic rx_valid,
  input wire logic rx_extended,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_len,
  output logic sync_seen,
  output logic rx_refused,
  // outgoing identifier
  input wire logic [3:0] tx_func,
  input wire logic [6:0] node_pin,
  output logic [10:0] tx_ident
);

  localparam int HSEL_W = $clog2(objdir_pkg::HIST_DEPTH);
  localparam int HCNT_W = HSEL_W + 1;

  logic [7:0] esum_q;
  logic [10:0] sync_id_q;
  logic sync_free_q;
  logic [31:0] status_q;
  logic [6:0] node_m_q;
  logic [6:0] node_q;
  logic [10:0] tx_ident_q;
  logic done_q;
  logic abort_q;
  logic [31:0] rdata_q;
  logic [31:0] abort_code_q;
  logic maker_q;
  logic map_done_q;
  logic map_ok_q;
  logic sync_seen_q;
  logic rx_refused_q;
  logic [31:0] rd_d;
  logic [31:0] abort_code_d;
  logic abort_d;
  logic wr_sync;
  logic wr_hist;
  logic [31:0] hist_rd;
  logic [HCNT_W-1:0] hist_cnt;
  logic [HSEL_W-1:0] hist_sel;
  logic in_comm;
  logic in_maker;
  logic frame_ok;

  // ****************************************
  // segment decode and access decision
  // ****************************************
  assign in_comm = (acc_index >= objdir_pkg::COMM_SEG_LO) &&
                   (acc_index <= objdir_pkg::COMM_SEG_HI);
  assign in_maker = acc_index >= objdir_pkg::MAKER_SEG_LO;
  assign hist_sel = HSEL_W'(acc_sub - objdir_pkg::SUB_NEWEST);

  // read value, abort decision and write strobes for one access
  always_comb begin
    rd_d = '0;
    abort_d = 1'b0;
    abort_code_d = '0;
    wr_sync = 1'b0;
    wr_hist = 1'b0;
    if (!in_comm) begin
      abort_d = 1'b1;
      abort_code_d = objdir_pkg::ABORT_NO_OBJECT;
    end else begin
      unique case (acc_index)
        objdir_pkg::IDX_DEVICE_KIND, objdir_pkg::IDX_ERROR_SUMMARY,
        objdir_pkg::IDX_MAKER_STATUS: begin
          if (acc_sub != objdir_pkg::SUB_ZERO) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_NO_SUB;
          end else if (acc_write) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_READ_ONLY;
          end else if (acc_index == objdir_pkg::IDX_DEVICE_KIND) begin
            rd_d = objdir_pkg::DEVICE_KIND_VAL;
          end else if (acc_index == objdir_pkg::IDX_ERROR_SUMMARY) begin
            rd_d = {24'h000000, esum_q};
          end else begin
            rd_d = status_q;
          end
        end
        objdir_pkg::IDX_ERROR_HISTORY: begin
          if (acc_sub > objdir_pkg::SUB_OLDEST) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_NO_SUB;
          end else if (acc_sub == objdir_pkg::SUB_ZERO) begin
            if (acc_write && acc_wdata != 32'h0000_0000) begin
              abort_d = 1'b1;
              abort_code_d = objdir_pkg::ABORT_BAD_VALUE;
            end else begin
              wr_hist = acc_write;
              rd_d = 32'(hist_cnt);
            end
          end else if (acc_write) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_READ_ONLY;
          end else begin
            rd_d = hist_rd;
          end
        end
        objdir_pkg::IDX_SYNC_ID: begin
          if (acc_sub != objdir_pkg::SUB_ZERO) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_NO_SUB;
          end else if (acc_write && (acc_wdata[objdir_pkg::SYNC_BIT_PRODUCE] ||
                                     acc_wdata[objdir_pkg::SYNC_BIT_EXT])) begin
            abort_d = 1'b1;
            abort_code_d = objdir_pkg::ABORT_BAD_VALUE;
          end else begin
            wr_sync = acc_write;
            rd_d = {sync_free_q, 20'h00000, sync_id_q};
          end
        end
        default: begin
          abort_d = 1'b1;
          abort_code_d = objdir_pkg::ABORT_NO_OBJECT;
        end
      endcase
    end
  end

  // ****************************************
  // access answer, one cycle after the request
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= '0;
      abort_code_q <= '0;
      maker_q <= 1'b0;
    end else begin
      done_q <= acc_req;
      abort_q <= acc_req && abort_d;
      rdata_q <= (acc_req && !abort_d && !acc_write) ? rd_d : '0;
      abort_code_q <= acc_req ? abort_code_d : '0;
      maker_q <= acc_req && in_maker;
    end
  end

  // ****************************************
  // writable objects
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_id_q <= objdir_pkg::SYNC_ID_RESET;
      sync_free_q <= 1'b0;
    end else if (acc_req && wr_sync) begin
      sync_id_q <= acc_wdata[objdir_pkg::SYNC_ID_W-1:0];
      sync_free_q <= acc_wdata[objdir_pkg::SYNC_BIT_FREE];
    end
  end

  // error summary: live bits only, setting wins over clearing
  always_ff @(posedge clk) begin
    if (rst) begin
      esum_q <= 8'h00;
    end else if (err_raise) begin
      esum_q[objdir_pkg::ESUM_GENERIC] <= 1'b1;
      esum_q[objdir_pkg::ESUM_COMM] <= err_comm | (esum_q[objdir_pkg::ESUM_COMM] &
                                                   !err_all_clear);
    end else if (err_all_clear) begin
      esum_q <= 8'h00;
    end
  end

  // maker status snapshot from device logic on this clock
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= maker_status;
    end
  end

  // error history entries
  error_history #(
    .DEPTH(objdir_pkg::HIST_DEPTH),
    .W(32)
  ) u_history (
    .clk(clk),
    .rst(rst),
    .push(err_raise),
    .push_data(err_code),
    .clear(acc_req && wr_hist),
    .rd_sel(hist_sel),
    .rd_data(hist_rd),
    .count(hist_cnt)
  );

  // ****************************************
  // mapping query
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      map_done_q <= 1'b0;
      map_ok_q <= 1'b0;
    end else begin
      map_done_q <= map_req;
      map_ok_q <= map_req && map_index == MAP_INDEX && map_sub == MAP_SUB;
    end
  end

  // ****************************************
  // received frames and sync detection
  // ****************************************
  assign frame_ok = !rx_extended && rx_len <= objdir_pkg::MAX_DATA_BYTES;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_seen_q <= 1'b0;
      rx_refused_q <= 1'b0;
    end else begin
      sync_seen_q <= rx_valid && frame_ok && rx_id == sync_id_q;
      rx_refused_q <= rx_valid && !frame_ok;
    end
  end

  // ****************************************
  // node number and outgoing identifier
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      node_m_q <= '0;
      node_q <= '0;
      tx_ident_q <= '0;
    end else begin
      node_m_q <= node_pin;
      node_q <= node_m_q;
      tx_ident_q <= {tx_func, node_q};
    end
  end

  assign acc_done = done_q;
  assign acc_rdata = rdata_q;
  assign acc_abort = abort_q;
  assign acc_abort_code = abort_code_q;
  assign acc_maker_seg = maker_q;
  assign map_done = map_done_q;
  assign map_ok = map_ok_q;
  assign sync_seen = sync_seen_q;
  assign rx_refused = rx_refused_q;
  assign tx_ident = tx_ident_q;

  // ****************************************
  // checks
  // ****************************************
  a_ext_refused: assert property (@(posedge clk) disable iff (rst)
    rx_valid && rx_extended |=> rx_refused && !sync_seen)
    else $error("extended frame was not refused");
  a_long_refused: assert property (@(posedge clk) disable iff (rst)
    rx_valid && rx_len > 4'h8 |=> rx_refused)
    else $error("frame with more than 8 bytes accepted");
  a_sync_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> sync_id_q == 11'h080 && !sync_free_q)
    else $error("sync identifier not at reset value");
  a_kind_zero: assert property (@(posedge clk) disable iff (rst)
    acc_req && !acc_write && acc_index == 16'h1000 && acc_sub == 8'h00
    |=> acc_done && !acc_abort && acc_rdata == 32'h0000_0000)
    else $error("device kind read not zero");
  a_outside_abort: assert property (@(posedge clk) disable iff (rst)
    acc_req && acc_index < 16'h1000 |=> acc_abort && acc_abort_code == 32'h0602_0000)
    else $error("access below segment not aborted");
  a_raise_generic: assert property (@(posedge clk) disable iff (rst)
    err_raise ##1 !err_all_clear ##1 (acc_req && !acc_write && acc_index == 16'h1001 &&
    acc_sub == 8'h00) |=> acc_rdata[0])
    else $error("generic error bit not set");
  a_summary_resv: assert property (@(posedge clk) disable iff (rst)
    (esum_q & ~8'h11) == 8'h00)
    else $error("reserved summary bit set");
  a_sync_bits: assert property (@(posedge clk) disable iff (rst)
    acc_req && acc_write && acc_index == 16'h1005 && acc_sub == 8'h00 &&
    acc_wdata[30] |=> acc_abort && $stable(sync_id_q))
    else $error("sync word with bit 30 accepted");
  a_map_refuse: assert property (@(posedge clk) disable iff (rst)
    map_req && map_index != MAP_INDEX |=> map_done && !map_ok)
    else $error("unmappable object mapped");
  a_tx_ident: assert property (@(posedge clk) disable iff (rst)
    ##3 tx_ident == {$past(tx_func), $past(node_pin, 3)})
    else $error("outgoing identifier mismatch");

endmodule

// file: verification/config_master.sv
// partner model: configuration master issuing directory accesses
// assumes the directory answers on its access port within a few cycles
`timescale 1ns/100ps
module config_master (
  // clock
  input wire logic clk,
  // request side
  output logic acc_req,
  output logic acc_write,
  output logic [15:0] acc_index,
  output logic [7:0] acc_sub,
  output logic [31:0] acc_wdata,
  // answer side
  input wire logic acc_done,
  input wire logic [31:0] acc_rdata,
  input wire logic acc_abort,
  input wire logic [31:0] acc_abort_code
);
  // idle lines from time zero
  initial begin
    acc_req = 1'b0;
    acc_write = 1'b0;
    acc_index = 16'h0000;
    acc_sub = 8'h00;
    acc_wdata = 32'h0000_0000;
  end

  // one access: pulse the request, hold qualifiers until the answer, then scramble them
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output logic done, output logic ab,
                      output logic [31:0] rd, output logic [31:0] code);
    int n;
    n = 0;
    @(negedge clk);
    acc_req = 1'b1;
    acc_write = w;
    acc_index = idx;
    acc_sub = sub;
    acc_wdata = wd;
    @(negedge clk);
    acc_req = 1'b0;
    while (acc_done !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    done = acc_done;
    ab = acc_abort;
    rd = acc_rdata;
    code = acc_abort_code;
    acc_write = ~w;
    acc_index = ~idx;
    acc_sub = ~sub;
    acc_wdata = ~wd;
  endtask
endmodule

// file: verification/tb_sensor_object_directory.sv
// testbench: directory accesses, errors, frames, mapping and identifier checks
// assumes the config_master partner model and the objdir_pkg package
`timescale 1ns/100ps
module tb_sensor_object_directory;
  logic clk, rst, acc_req, acc_write, acc_done, acc_abort, acc_maker_seg;
  logic [15:0] acc_index, map_index;
  logic [7:0] acc_sub, map_sub, esum_m;
  logic [31:0] acc_wdata, acc_rdata, acc_abort_code, err_code, maker_status;
  logic map_req, map_done, map_ok, err_raise, err_comm, err_all_clear;
  logic rx_valid, rx_extended, sync_seen, rx_refused;
  logic [10:0] rx_id, tx_ident;
  logic [3:0] rx_len, tx_func;
  logic [6:0] node_pin;
  logic [31:0] rnd_q, sync_m, mstat_m, wd, r;
  logic [31:0] hist_m[$];
  int mismatches, comparisons, cycles;

  // ****************************************
  // instances
  // ****************************************
  config_master cm (.clk(clk), .acc_req(acc_req), .acc_write(acc_write),
    .acc_index(acc_index), .acc_sub(acc_sub), .acc_wdata(acc_wdata), .acc_done(acc_done),
    .acc_rdata(acc_rdata), .acc_abort(acc_abort), .acc_abort_code(acc_abort_code));
  sensor_object_directory dut (.clk(clk), .rst(rst), .acc_req(acc_req),
    .acc_write(acc_write), .acc_index(acc_index), .acc_sub(acc_sub), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_rdata(acc_rdata), .acc_abort(acc_abort),
    .acc_abort_code(acc_abort_code), .acc_maker_seg(acc_maker_seg), .map_req(map_req),
    .map_index(map_index), .map_sub(map_sub), .map_done(map_done), .map_ok(map_ok),
    .err_raise(err_raise), .err_comm(err_comm), .err_code(err_code),
    .err_all_clear(err_all_clear), .maker_status(maker_status), .rx_valid(rx_valid),
    .rx_extended(rx_extended), .rx_id(rx_id), .rx_len(rx_len), .sync_seen(sync_seen),
    .rx_refused(rx_refused), .tx_func(tx_func), .node_pin(node_pin), .tx_ident(tx_ident));

  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  // free running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  function automatic logic [31:0] rnd();
    rnd_q ^= rnd_q << 13;
    rnd_q ^= rnd_q >> 17;
    rnd_q ^= rnd_q << 5;
    return rnd_q;
  endfunction

  task automatic close_out();
    $display("counts: mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  // ****************************************
  // reference model of the directory
  // ****************************************
  task automatic model(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, output logic [31:0] rd, output logic [31:0] code);
    rd = 32'h0000_0000;
    code = 32'h0000_0000;
    if (idx < 16'h1000 || idx > 16'h1fff) begin
      code = objdir_pkg::ABORT_NO_OBJECT;
    end else if (idx == 16'h1003) begin
      if (sub > 8'h20) code = objdir_pkg::ABORT_NO_SUB;
      else if (sub != 8'h00 && w) code = objdir_pkg::ABORT_READ_ONLY;
      else if (sub != 8'h00) rd = (sub <= hist_m.size()) ? hist_m[sub - 1] : 32'h0000_0000;
      else if (!w) rd = 32'(hist_m.size());
      else if (d != 32'h0000_0000) code = objdir_pkg::ABORT_BAD_VALUE;
      else hist_m.delete();
    end else if (idx inside {16'h1000, 16'h1001, 16'h1002, 16'h1005}) begin
      if (sub != 8'h00) code = objdir_pkg::ABORT_NO_SUB;
      else if (w && idx != 16'h1005) code = objdir_pkg::ABORT_READ_ONLY;
      else if (w && (d[30] || d[29])) code = objdir_pkg::ABORT_BAD_VALUE;
      else if (w) sync_m = d & 32'h8000_07ff;
      else if (idx == 16'h1001) rd = {24'h000000, esum_m};
      else if (idx == 16'h1002) rd = mstat_m;
      else if (idx == 16'h1005) rd = sync_m;
    end else begin
      code = objdir_pkg::ABORT_NO_OBJECT;
    end
  endtask

  // ****************************************
  // stimulus tasks
  // ****************************************
  // one access through the partner, compared field by field with the model
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] d);
    logic dn, ab;
    logic [31:0] rd, code, erd, ecode;
    model(w, idx, sub, d, erd, ecode);
    cm.xfer(w, idx, sub, d, dn, ab, rd, code);
    chk_bit("acc_done", 1'b1, dn);
    chk_bit("acc_abort", ecode != 32'h0000_0000, ab);
    chk("acc_abort_code", ecode, code);
    chk("acc_rdata", erd, rd);
    chk_bit("acc_maker_seg", idx >= 16'h2000, acc_maker_seg);
  endtask

  task automatic frame(input logic ext, input logic [10:0] id, input logic [3:0] len);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_extended = ext;
    rx_id = id;
    rx_len = len;
    @(negedge clk);
    rx_valid = 1'b0;
    chk_bit("sync_seen", !ext && len <= 4'h8 && id == sync_m[10:0], sync_seen);
    chk_bit("rx_refused", ext || len > 4'h8, rx_refused);
  endtask

  task automatic raise(input logic comm, input logic [31:0] code);
    @(negedge clk);
    err_raise = 1'b1;
    err_comm = comm;
    err_code = code;
    @(negedge clk);
    err_raise = 1'b0;
    hist_m.push_front(code);
    if (hist_m.size() > 32) void'(hist_m.pop_back());
    esum_m |= comm ? 8'h11 : 8'h01;
  endtask

  task automatic mapq(input logic [15:0] idx, input logic [7:0] sub, input logic ok);
    @(negedge clk);
    map_req = 1'b1;
    map_index = idx;
    map_sub = sub;
    @(negedge clk);
    map_req = 1'b0;
    chk_bit("map_done", 1'b1, map_done);
    chk_bit("map_ok", ok, map_ok);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rnd_q = 32'h0000_001e;
    {map_req, map_index, map_sub, err_raise, err_comm, err_code, err_all_clear} = '0;
    {rx_valid, rx_extended, rx_id, rx_len, tx_func, node_pin} = '0;
    maker_status = rnd();
    mstat_m = maker_status;
    sync_m = 32'h0000_0080;
    esum_m = 8'h00;
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 16'h1000, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1001, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1002, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1005, 8'h00, 32'h0000_0000);
    for (int i = 0; i < 3; i++) acc(1'b1, 16'h1000 + 16'(i), 8'h00, rnd());
    acc(1'b0, 16'h1001, 8'h00, 32'h0000_0000);
    acc(1'b1, 16'h1003, 8'h01, rnd());
    acc(1'b0, 16'h0fff, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1004, 8'h00, 32'h0000_0000);
    acc(1'b1, 16'h2000, 8'h00, rnd());
    acc(1'b0, 16'hffff, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1000, 8'h01, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h21, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      wd = rnd() & 32'h9fff_ffff;
      acc(1'b1, 16'h1005, 8'h00, wd);
      acc(1'b0, 16'h1005, 8'h00, 32'h0000_0000);
    end
    acc(1'b1, 16'h1005, 8'h00, 32'h4000_0080);
    acc(1'b1, 16'h1005, 8'h00, 32'h2000_0080);
    acc(1'b0, 16'h1005, 8'h00, 32'h0000_0000);
    frame(1'b0, sync_m[10:0], 4'h0);
    frame(1'b0, sync_m[10:0], 4'h8);
    frame(1'b0, sync_m[10:0], 4'h9);
    frame(1'b1, sync_m[10:0], 4'h0);
    frame(1'b0, ~sync_m[10:0], 4'h3);
    for (int i = 0; i < 34; i++) begin
      r = rnd();
      raise(i > 1 && r[0], rnd());
      if (i == 2) begin
        acc(1'b0, 16'h1001, 8'h00, 32'h0000_0000);
        acc(1'b0, 16'h1003, 8'h04, 32'h0000_0000);
      end
    end
    acc(1'b0, 16'h1001, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h01, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h20, 32'h0000_0000);
    acc(1'b1, 16'h1003, 8'h00, 32'h0000_0001);
    acc(1'b0, 16'h1003, 8'h20, 32'h0000_0000);
    acc(1'b1, 16'h1003, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h00, 32'h0000_0000);
    acc(1'b0, 16'h1003, 8'h01, 32'h0000_0000);
    @(negedge clk);
    err_all_clear = 1'b1;
    @(negedge clk);
    err_all_clear = 1'b0;
    esum_m = 8'h00;
    acc(1'b0, 16'h1001, 8'h00, 32'h0000_0000);
    mapq(16'h2000, 8'h00, 1'b1);
    mapq(16'h1000, 8'h00, 1'b0);
    mapq(16'h2000, 8'h01, 1'b0);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      tx_func = r[3:0];
      node_pin = r[10:4];
      repeat (5) @(negedge clk);
      chk("tx_ident", {21'h000000, r[3:0], r[10:4]}, {21'h000000, tx_ident});
    end
    close_out();
  end
endmodule
